// *** spbpp_checker_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spbpp_regs.vh"
module spbpp_checker (
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxShiftLoad,
	input wire logic txShiftTake,
	input wire logic txShiftAvail,
	input wire logic debugSuspend,
	input wire logic shiftFreeze,
	input wire logic txPinOe,
	input wire logic rxPinOe,
	input wire logic irqHighPri,
	input wire logic irqLowPri
);
	// one clock domain, so clock and reset are given once
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// tx buffer write cycle; a same-edge take loses to it
	wire txWr = psel && penable && pwrite && paddr == {`SPBPP_IDX_TX_BUF, 2'b00};
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("error flag without ready");
	a_irq_has_cause: assert property ((irqHighPri || irqLowPri) |->
		$past(rxShiftLoad) || $past(txShiftTake && txShiftAvail))
		else $error("interrupt without a buffer transfer");
	a_txw_fills: assert property (txWr && !pready |=> txShiftAvail)
		else $error("tx write left buffer free");
	a_take_empties: assert property (txShiftTake && txShiftAvail && !shiftFreeze && !txWr
		|=> !txShiftAvail)
		else $error("take did not free the tx buffer");
	a_freeze_suspend: assert property (!debugSuspend |=> !shiftFreeze)
		else $error("freeze without suspend");
	a_txoe_by_write: assert property ($changed(txPinOe) |->
		$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
		else $error("tx pin enable moved without a write");
	a_rxoe_by_write: assert property ($changed(rxPinOe) |->
		$past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
		else $error("rx pin enable moved without a write");
endmodule // spbpp_checker
bind spbpp_top spbpp_checker spbpp_checker_i (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.rxShiftLoad(rxShiftLoad), .txShiftTake(txShiftTake), .txShiftAvail(txShiftAvail),
	.debugSuspend(debugSuspend), .shiftFreeze(shiftFreeze), .txPinOe(txPinOe),
	.rxPinOe(rxPinOe), .irqHighPri(irqHighPri), .irqLowPri(irqLowPri));
`default_nettype wire

// *** spbpp_regs.vh ***
`ifndef SPBPP_REGS_VH
`define SPBPP_REGS_VH
// register indices; byte address is four times the index
`define SPBPP_IDX_RX_DEBUG_VIEW 16'h7056
`define SPBPP_IDX_RX_BUF 16'h7057
`define SPBPP_IDX_TX_BUF 16'h7059
`define SPBPP_IDX_PIN_CTRL 16'h705E
`define SPBPP_IDX_PRIORITY 16'h705F
`define SPBPP_IDX_CONTROL 16'h7054
`define SPBPP_IDX_STATUS 16'h7055
`define SPBPP_IDX_CHAR_LEN 16'h7050
// pin control fields
`define SPBPP_PC_TX_IN 7
`define SPBPP_PC_TX_OUT 6
`define SPBPP_PC_TX_FUNC 5
`define SPBPP_PC_TX_DIR 4
`define SPBPP_PC_RX_IN 3
`define SPBPP_PC_RX_OUT 2
`define SPBPP_PC_RX_FUNC 1
`define SPBPP_PC_RX_DIR 0
// priority fields
`define SPBPP_PRI_TX_LOW 6
`define SPBPP_PRI_RX_LOW 5
`define SPBPP_PRI_FREEZE 4
// control fields
`define SPBPP_CTL_RX_IRQ_EN 1
`define SPBPP_CTL_TX_IRQ_EN 0
// status fields
`define SPBPP_ST_TX_FREE 7
`define SPBPP_ST_RX_READY 6
// reset values
`define SPBPP_RST_BYTE 8'h00
`define SPBPP_RST_LEN 4'h8
`define SPBPP_FULL_LEN 4'h8
`endif

// *** spbpp_remote_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------
// far-side serial device on the two pins
// ----------
module spbpp_remote_model (
	input wire logic txOe,
	input wire logic txOut,
	input wire logic rxOe,
	input wire logic rxOut,
	input wire logic remTx,
	input wire logic remRx,
	output logic txLine,
	output logic rxLine
);
	// whoever enables its driver owns the wire; the far side fills in otherwise
	assign txLine = txOe ? txOut : remTx;
	assign rxLine = rxOe ? rxOut : remRx;
endmodule // spbpp_remote_model
`default_nettype wire

// *** spbpp_sync2.v ***
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for pin levels
module spbpp_sync2 #(
	parameter WIDTH = 2
) (
	input wire clock,
	input wire rst,
	input wire [WIDTH-1:0] asyncIn,
	output reg [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] meta_q;

	// -------------------------------------------------
	// capture stages
	// -------------------------------------------------
	// first stage feeds only the second one
	always @(posedge clock) begin
		if (rst) begin
			meta_q <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // spbpp_sync2
`default_nettype wire

// *** spbpp_top.v ***
`timescale 1ns/1ps
`default_nettype none
`include "spbpp_regs.vh"
// Function
// (R1) receive-buffer load sets the receiver-ready flag
// (R2) with receive irq enabled, each buffer load raises a receiver request
// (R3) reading the receive buffer clears the receiver-ready flag
// (R4) system reset clears the receive buffer
// (R5) transmit buffer moving to the shifter sets the buffer-free flag
// (R6) with transmit irq enabled, that move raises a transmitter request
// (R7) short characters are right-justified; unused upper bits ignored
// (R8) pin control bit 7 reads the transmit pin level
// (R9) pin control bit 6 drives the transmit pin as a general output
// (R10) pin control bit 5 picks transmit pin function: general or serial
// (R11) pin control bit 4 sets transmit pin direction in general mode
// (R12) pin control bit 3 reads the receive pin level
// (R13) pin control bit 2 drives the receive pin as a general output
// (R14) pin control bit 1 picks receive pin function: general or serial
// (R15) pin control bit 0 sets receive pin direction in general mode
// (R16) priority bit 6 routes transmitter requests high (0) or low (1)
// (R17) priority bit 5 routes receiver requests high (0) or low (1)
// (R18) under suspend: bit 4 clear finishes current work, set freezes
// (R19) priority bits 7 and 3..0 ignore writes
// (R20) writing the transmit buffer clears the buffer-free flag
// (R21) debug view reads the received character without clearing ready
// (R22) in serial function, general data and direction bits are ignored
module spbpp_top (
	input wire clock,
	input wire rst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [17:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rxShiftLoad,
	input wire [7:0] rxShiftData,
	input wire txShiftTake,
	output reg [7:0] txShiftData,
	output reg txShiftAvail,
	input wire txSerialOut,
	output reg rxSerialIn,
	input wire debugSuspend,
	output reg shiftFreeze,
	output reg txPinOut,
	output reg txPinOe,
	input wire txPinIn,
	output reg rxPinOut,
	output reg rxPinOe,
	input wire rxPinIn,
	output reg irqHighPri,
	output reg irqLowPri
);
	localparam ST_IDLE = 2'b00;
	localparam ST_ACCESS = 2'b01;
	localparam ST_DONE = 2'b10;

	// register state
	reg [1:0] state_q;
	reg [7:0] rxBuf_q;
	reg [7:0] txBuf_q;
	reg rxReady_q;
	reg txFree_q;
	reg txFull_q;
	reg [7:0] pinCtrl_q;
	reg [2:0] pri_q;
	reg [1:0] ctl_q;
	reg [3:0] charLen_q;
	reg frozen_q;
	wire [1:0] pinSync;
	wire [15:0] regIdx;
	wire wrStrobe;
	wire rdStrobe;
	wire rxIrqEvent;
	wire txIrqEvent;
	wire txTakeOk;
	wire rxLoadOk;

	// -------------------------------------------------
	// helpers
	// -------------------------------------------------
	// mask of bits kept for a given character length
	// a zero-length mask cannot occur: charLen_q is held in 1..8
	function [7:0] lenMask;
		input [3:0] len;
		begin
			lenMask = 8'hFF >> (`SPBPP_FULL_LEN - len);
		end
	endfunction

	// true when the bus address hits a given register index
	function hit;
		input [15:0] idx;
		input [15:0] want;
		begin
			hit = (idx == want);
		end
	endfunction

	// -------------------------------------------------
	// pin level synchronisers
	// -------------------------------------------------
	// both pin levels share one synchroniser
	spbpp_sync2 #(
		.WIDTH(2)
	) pinSyncInst (
		.clock(clock),
		.rst(rst),
		.asyncIn({txPinIn, rxPinIn}),
		.syncOut(pinSync)
	);

	// -------------------------------------------------
	// bus decode
	// -------------------------------------------------
	// word address is the register index; low two bits ignored
	// only the access cycle in ST_ACCESS strobes, so a write lands once
	assign regIdx = paddr[17:2];
	assign wrStrobe = (state_q == ST_ACCESS) && psel && penable && pwrite;
	assign rdStrobe = (state_q == ST_ACCESS) && psel && penable && !pwrite;

	// freeze halts transfers with the shifters at once
	// a frozen shifter neither loads nor takes, so no request follows
	assign rxLoadOk = rxShiftLoad && !frozen_q; // [R18]
	assign txTakeOk = txShiftTake && txFull_q && !frozen_q; // [R18]
	assign rxIrqEvent = rxLoadOk && ctl_q[`SPBPP_CTL_RX_IRQ_EN]; // [R2]
	assign txIrqEvent = txTakeOk && ctl_q[`SPBPP_CTL_TX_IRQ_EN]; // [R6]

	// -------------------------------------------------
	// bus state machine: one wait state, then pready
	// -------------------------------------------------
	// hazard: a master that skips the setup cycle is never answered
	always @(posedge clock) begin
		if (rst) begin
			state_q <= ST_IDLE;
			pready <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					pready <= 1'b0;
					if (psel && !penable) begin
						state_q <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (psel && penable) begin
						state_q <= ST_DONE;
						pready <= 1'b1;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					pready <= 1'b0;
				end
			endcase
		end
	end

	// -------------------------------------------------
	// read data and error answer
	// -------------------------------------------------
	// captured during access so the data come from flops with pready
	// bits above the byte lane always read zero
	always @(posedge clock) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (rdStrobe || wrStrobe) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			if (wrStrobe) begin
				if (!(hit(regIdx, `SPBPP_IDX_TX_BUF) || hit(regIdx, `SPBPP_IDX_PIN_CTRL) ||
					hit(regIdx, `SPBPP_IDX_PRIORITY) || hit(regIdx, `SPBPP_IDX_CONTROL) ||
					hit(regIdx, `SPBPP_IDX_CHAR_LEN))) begin
					pslverr <= 1'b1;
				end
			end else if (hit(regIdx, `SPBPP_IDX_RX_BUF)) begin
				prdata[7:0] <= rxBuf_q;
			end else if (hit(regIdx, `SPBPP_IDX_RX_DEBUG_VIEW)) begin
				prdata[7:0] <= rxBuf_q; // [R21]
			end else if (hit(regIdx, `SPBPP_IDX_TX_BUF)) begin
				prdata[7:0] <= txBuf_q;
			end else if (hit(regIdx, `SPBPP_IDX_PIN_CTRL)) begin
				prdata[7:0] <= {pinSync[1], pinCtrl_q[6:4], pinSync[0], pinCtrl_q[2:0]}; // [R8] [R12]
			end else if (hit(regIdx, `SPBPP_IDX_PRIORITY)) begin
				prdata[7:0] <= {1'b0, pri_q, 4'h0}; // [R19]
			end else if (hit(regIdx, `SPBPP_IDX_CONTROL)) begin
				prdata[7:0] <= {txFree_q, 5'h00, ctl_q};
			end else if (hit(regIdx, `SPBPP_IDX_STATUS)) begin
				prdata[7:0] <= {1'b0, rxReady_q, 6'h00};
			end else if (hit(regIdx, `SPBPP_IDX_CHAR_LEN)) begin
				prdata[3:0] <= charLen_q;
			end else begin
				pslverr <= 1'b1;
			end
		end else begin
			// error flag stands one cycle, like pready
			pslverr <= 1'b0;
		end
	end

	// -------------------------------------------------
	// configuration registers
	// -------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			pinCtrl_q <= `SPBPP_RST_BYTE;
			pri_q <= 3'b000;
			ctl_q <= 2'b00;
			charLen_q <= `SPBPP_RST_LEN;
		end else if (wrStrobe) begin
			if (hit(regIdx, `SPBPP_IDX_PIN_CTRL)) begin
				// input-level bits are read-only, kept zero here
				pinCtrl_q <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
			end else if (hit(regIdx, `SPBPP_IDX_PRIORITY)) begin
				pri_q <= pwdata[6:4]; // [R16] [R17] [R19]
			end else if (hit(regIdx, `SPBPP_IDX_CONTROL)) begin
				// upper control bits are not stored; free flag reads from txFree_q
				ctl_q <= pwdata[1:0];
			end else if (hit(regIdx, `SPBPP_IDX_CHAR_LEN)) begin
				// lengths outside 1..8 fall back to full width
				if (pwdata[3:0] != 4'h0 && pwdata[3:0] <= `SPBPP_FULL_LEN) begin
					charLen_q <= pwdata[3:0];
				end else begin
					charLen_q <= `SPBPP_FULL_LEN;
				end
			end
		end
	end

	// -------------------------------------------------
	// receive buffer and ready flag
	// -------------------------------------------------
	// a load in the same cycle as the clearing read wins
	// overrun simply overwrites; error flags live outside this block
	always @(posedge clock) begin
		if (rst) begin
			rxBuf_q <= `SPBPP_RST_BYTE; // [R4]
			rxReady_q <= 1'b0;
		end else if (rxLoadOk) begin
			rxBuf_q <= rxShiftData & lenMask(charLen_q);
			rxReady_q <= 1'b1; // [R1]
		end else if (rdStrobe && hit(regIdx, `SPBPP_IDX_RX_BUF)) begin
			rxReady_q <= 1'b0; // [R3]
		end
	end

	// -------------------------------------------------
	// transmit buffer and free flag
	// -------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			txBuf_q <= `SPBPP_RST_BYTE;
			txFree_q <= 1'b1;
			txFull_q <= 1'b0;
		end else if (wrStrobe && hit(regIdx, `SPBPP_IDX_TX_BUF)) begin
			// a write beats a same-cycle take, so the new character is kept
			txBuf_q <= pwdata[7:0] & lenMask(charLen_q); // [R7]
			txFree_q <= 1'b0; // [R20]
			txFull_q <= 1'b1;
		end else if (txTakeOk) begin
			txFree_q <= 1'b1; // [R5]
			txFull_q <= 1'b0;
		end
	end

	// offer to the shifter; data masked to the character length
	always @(posedge clock) begin
		if (rst) begin
			txShiftData <= `SPBPP_RST_BYTE;
			txShiftAvail <= 1'b0;
		end else begin
			txShiftData <= txBuf_q; // [R7]
			txShiftAvail <= txFull_q && !txTakeOk && !(wrStrobe && hit(regIdx, `SPBPP_IDX_TX_BUF))
				? 1'b1 : (wrStrobe && hit(regIdx, `SPBPP_IDX_TX_BUF));
		end
	end

	// -------------------------------------------------
	// suspend handling
	// -------------------------------------------------
	// only the freeze option stops the shifters; otherwise they run on
	// without freeze the shifters finish their frame on their own
	always @(posedge clock) begin
		if (rst) begin
			frozen_q <= 1'b0;
			shiftFreeze <= 1'b0;
		end else begin
			frozen_q <= debugSuspend && pri_q[`SPBPP_PRI_FREEZE - 4]; // [R18]
			shiftFreeze <= debugSuspend && pri_q[`SPBPP_PRI_FREEZE - 4]; // [R18]
		end
	end

	// -------------------------------------------------
	// interrupt priority routing: one-cycle pulses
	// -------------------------------------------------
	always @(posedge clock) begin
		if (rst) begin
			irqHighPri <= 1'b0;
			irqLowPri <= 1'b0;
		end else begin
			// both lines may pulse together when rx and tx events coincide
			irqHighPri <= (rxIrqEvent && !pri_q[`SPBPP_PRI_RX_LOW - 4]) ||
				(txIrqEvent && !pri_q[`SPBPP_PRI_TX_LOW - 4]); // [R16] [R17]
			irqLowPri <= (rxIrqEvent && pri_q[`SPBPP_PRI_RX_LOW - 4]) ||
				(txIrqEvent && pri_q[`SPBPP_PRI_TX_LOW - 4]); // [R16] [R17]
		end
	end

	// -------------------------------------------------
	// pin muxing
	// -------------------------------------------------
	// serial function overrides the general data and direction bits
	// serial rx is input-only, so its driver is released there
	always @(posedge clock) begin
		if (rst) begin
			txPinOut <= 1'b0;
			txPinOe <= 1'b0;
			rxPinOut <= 1'b0;
			rxPinOe <= 1'b0;
			rxSerialIn <= 1'b1;
		end else begin
			if (pinCtrl_q[`SPBPP_PC_TX_FUNC]) begin // [R10]
				txPinOut <= txSerialOut; // [R22]
				txPinOe <= 1'b1;
			end else begin
				txPinOut <= pinCtrl_q[`SPBPP_PC_TX_OUT]; // [R9]
				txPinOe <= pinCtrl_q[`SPBPP_PC_TX_DIR]; // [R11]
			end
			if (pinCtrl_q[`SPBPP_PC_RX_FUNC]) begin // [R14]
				rxPinOut <= 1'b0; // [R22]
				rxPinOe <= 1'b0;
				rxSerialIn <= pinSync[0];
			end else begin
				rxPinOut <= pinCtrl_q[`SPBPP_PC_RX_OUT]; // [R13]
				rxPinOe <= pinCtrl_q[`SPBPP_PC_RX_DIR]; // [R15]
				rxSerialIn <= 1'b1; // idle line while pin is general
			end
		end
	end
endmodule // spbpp_top
`default_nettype wire

// *** test_serial_port_buffers_pins_priority.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spbpp_regs.vh"
module test_serial_port_buffers_pins_priority;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, rxShiftLoad = 0, txShiftTake = 0;
	logic txSerialOut = 0, debugSuspend = 0, remTx = 0, remRx = 1, err;
	logic [17:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [7:0] rxShiftData = 0, txShiftData, d;
	logic pready, pslverr, txShiftAvail, rxSerialIn, shiftFreeze, txPinOut, txPinOe, txPinIn;
	logic rxPinOut, rxPinOe, rxPinIn, irqHighPri, irqLowPri;
	integer errTotal = 0, compares = 0, seed = 52965, hiCnt = 0, loCnt = 0, h0, l0, p;
	spbpp_top spbpp_top_i (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxShiftLoad(rxShiftLoad), .rxShiftData(rxShiftData),
		.txShiftTake(txShiftTake), .txShiftData(txShiftData), .txShiftAvail(txShiftAvail),
		.txSerialOut(txSerialOut), .rxSerialIn(rxSerialIn), .debugSuspend(debugSuspend),
		.shiftFreeze(shiftFreeze), .txPinOut(txPinOut), .txPinOe(txPinOe), .txPinIn(txPinIn),
		.rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .rxPinIn(rxPinIn), .irqHighPri(irqHighPri),
		.irqLowPri(irqLowPri));
	spbpp_remote_model spbpp_remote_model_i (.txOe(txPinOe), .txOut(txPinOut), .rxOe(rxPinOe),
		.rxOut(rxPinOut), .remTx(remTx), .remRx(remRx), .txLine(txPinIn), .rxLine(rxPinIn));
	// 200 MHz clock
	always #2.5 clock = ~clock;
	// interrupt pulses are one cycle wide, so tally them rather than poll
	always @(posedge clock) begin
		if (irqHighPri === 1'b1) hiCnt <= hiCnt + 1;
		if (irqLowPri === 1'b1) loCnt <= loCnt + 1;
	end
	task summarize;
		$display("compares %0d errors %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			errTotal = errTotal + 1;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until ready is seen at an edge
	task apb(input wr, input [15:0] idx, input [31:0] wd);
		integer n;
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= wd;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do begin @(posedge clock); n = n + 1; end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 50) chk(0, 1);
	endtask
	task settle;
		repeat (3) @(posedge clock);
	endtask
	task pulse(input rx);
		@(posedge clock);
		if (rx) rxShiftLoad <= 1; else txShiftTake <= 1;
		@(posedge clock);
		rxShiftLoad <= 0;
		txShiftTake <= 0;
		settle;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		chk(0, 1);
		summarize;
	end
	// ----------
	// main sequence
	// ----------
	initial begin
		repeat (10) @(posedge clock);
		rst <= 0;
		d = $random(seed);
		remRx <= d[0];
		apb(0, `SPBPP_IDX_RX_BUF, 0); chk(rd, 0);
		apb(0, `SPBPP_IDX_PRIORITY, 0); chk(rd, 0);
		apb(0, 16'h7051, 0); chk(rd | err, 1);
		apb(1, `SPBPP_IDX_CONTROL, 3);
		for (p = 0; p < 4; p = p + 1) begin
			apb(1, `SPBPP_IDX_PRIORITY, {p[1], p[0], 5'h00});
			d = $random(seed); h0 = hiCnt; l0 = loCnt; rxShiftData <= d;
			pulse(1);
			chk(hiCnt - h0, !p[0]); chk(loCnt - l0, p[0]);
			apb(0, `SPBPP_IDX_STATUS, 0); chk(rd[6], 1);
			apb(0, `SPBPP_IDX_RX_DEBUG_VIEW, 0); chk(rd, d);
			apb(0, `SPBPP_IDX_RX_BUF, 0); chk(rd, d);
			apb(0, `SPBPP_IDX_STATUS, 0); chk(rd[6], 0);
			d = $random(seed); h0 = hiCnt; l0 = loCnt;
			apb(1, `SPBPP_IDX_TX_BUF, d);
			settle;
			chk({txShiftAvail, txShiftData}, {1'b1, d});
			apb(0, `SPBPP_IDX_CONTROL, 0); chk(rd[7], 0);
			pulse(0);
			chk(hiCnt - h0, !p[1]); chk(loCnt - l0, p[1]);
			apb(0, `SPBPP_IDX_CONTROL, 0); chk(rd[7], 1);
		end
		apb(1, `SPBPP_IDX_CHAR_LEN, 5);
		apb(1, `SPBPP_IDX_TX_BUF, 32'hFF);
		settle;
		chk(txShiftData, 8'h1F);
		pulse(0);
		apb(1, `SPBPP_IDX_CHAR_LEN, 8);
		remTx <= 0;
		apb(1, `SPBPP_IDX_PIN_CTRL, 8'h50); settle; chk({txPinOe, txPinOut}, 2'b11);
		apb(0, `SPBPP_IDX_PIN_CTRL, 0); chk(rd, 8'hD0 | {remRx, 3'b000});
		apb(1, `SPBPP_IDX_PIN_CTRL, 8'h05); settle; chk({rxPinOe, rxPinOut, txPinOe}, 3'b110);
		apb(0, `SPBPP_IDX_PIN_CTRL, 0); chk(rd, 8'h0D | {remTx, 7'h00});
		txSerialOut <= d[3];
		apb(1, `SPBPP_IDX_PIN_CTRL, 8'h77); settle;
		settle;
		chk({txPinOe, txPinOut, rxPinOe, rxSerialIn}, {1'b1, d[3], 1'b0, remRx});
		apb(1, `SPBPP_IDX_PRIORITY, 32'hFF);
		apb(0, `SPBPP_IDX_PRIORITY, 0); chk(rd, 8'h70);
		@(posedge clock) debugSuspend <= 1;
		settle; chk(shiftFreeze, 1);
		rxShiftData <= d;
		pulse(1);
		apb(0, `SPBPP_IDX_STATUS, 0); chk(rd[6], 0);
		apb(1, `SPBPP_IDX_PRIORITY, 0); settle; chk(shiftFreeze, 0);
		pulse(1);
		apb(0, `SPBPP_IDX_STATUS, 0); chk(rd[6], 1);
		summarize;
	end
endmodule // test_serial_port_buffers_pins_priority
`default_nettype wire
